//--- design/ats_defines.vh
// Register map, field positions, reset values and timing counts of the timer
`ifndef ATS_DEFINES_VH
`define ATS_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ATS_OFF_CTRL_A 8'hb0
`define ATS_OFF_CTRL_B 8'hb4
`define ATS_OFF_COUNT 8'hb8
`define ATS_OFF_CMP_A 8'hbc
`define ATS_OFF_CMP_B 8'hc0
`define ATS_OFF_ASYNC_STAT 8'hc4
`define ATS_OFF_GEN_CTRL 8'hc8
`define ATS_OFF_FLAGS 8'hcc
`define ATS_OFF_IRQ_EN 8'hd0

// ****************************************
// Field positions
// ****************************************
`define ATS_CTLB_FORCE_A 7
`define ATS_CTLB_FORCE_B 6
`define ATS_CTLB_WGM_HI 3
`define ATS_STAT_AS 5
`define ATS_STAT_CNT_UB 4
`define ATS_STAT_CMPA_UB 3
`define ATS_STAT_CMPB_UB 2
`define ATS_STAT_CTLA_UB 1
`define ATS_STAT_CTLB_UB 0
`define ATS_GEN_PSR 1
`define ATS_FLAG_OVF 0
`define ATS_FLAG_CMPA 1
`define ATS_FLAG_CMPB 2

// ****************************************
// Reset values and counts
// ****************************************
`define ATS_RST_BYTE 8'h00
`define ATS_MAX 8'hff
`define ATS_BOTTOM 8'h00
`define ATS_XFER_LAST 2'd1
`define ATS_MODE_PC_FF 3'd1
`define ATS_MODE_CTC 3'd2
`define ATS_MODE_FAST_FF 3'd3
`define ATS_MODE_PC_OCR 3'd5
`define ATS_MODE_FAST_OCR 3'd7

`endif

//--- design/ats_upd_slot.v
// Temporary holding register with update-busy flag for one timer register
`timescale 1ns/10ps
`default_nettype none
`include "ats_defines.vh"

module ats_upd_slot #(
    parameter W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire wr_async,
    input wire wr_sync,
    input wire [W-1:0] wdata,
    input wire xtal_edge,
    output wire busy,
    output wire load,
    output wire [W-1:0] value
);

    reg [W-1:0] tmp_r;
    reg busy_r;
    reg [1:0] edges_r;
    wire done;

    // Second crystal edge after the write moves the value on
    assign done = busy_r & xtal_edge & (edges_r == `ATS_XFER_LAST); // RQ3

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmp_r <= {W{1'b0}};
            busy_r <= 1'b0;
            edges_r <= 2'd0;
        end else if (wr_async) begin
            // A new write wins over a completing transfer
            tmp_r <= wdata; // RQ4
            busy_r <= 1'b1; // RQ6
            edges_r <= 2'd0;
        end else if (busy_r && xtal_edge) begin
            if (done) begin
                busy_r <= 1'b0; // RQ6
            end
            edges_r <= edges_r + 2'd1;
        end
    end

    assign busy = busy_r; // RQ5
    assign load = wr_sync | done;
    assign value = wr_sync ? wdata : tmp_r;

endmodule // ats_upd_slot

`default_nettype wire

//--- design/ats_prescaler.v
// Timer prescaler with selectable divide ratio and reset
`timescale 1ns/10ps
`default_nettype none

module ats_prescaler #(
    parameter PW = 10
) (
    input wire pclk,
    input wire presetn,
    input wire src_tick,
    input wire clear,
    input wire [2:0] sel,
    output reg tick
);

    reg [PW-1:0] cnt_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {PW{1'b0}};
        end else if (clear) begin
            cnt_r <= {PW{1'b0}}; // RQ18
        end else if (src_tick) begin
            cnt_r <= cnt_r + {{(PW-1){1'b0}}, 1'b1};
        end
    end

    always @* begin
        case (sel) // RQ17 RQ27
            3'd0: tick = 1'b0;
            3'd1: tick = src_tick;
            3'd2: tick = src_tick & (&cnt_r[2:0]);
            3'd3: tick = src_tick & (&cnt_r[4:0]);
            3'd4: tick = src_tick & (&cnt_r[5:0]);
            3'd5: tick = src_tick & (&cnt_r[6:0]);
            3'd6: tick = src_tick & (&cnt_r[7:0]);
            default: tick = src_tick & (&cnt_r[9:0]);
        endcase
    end

endmodule // ats_prescaler

`default_nettype wire

//--- design/ats_timer.v
// Asynchronously clocked 8-bit timer with channel A compare output
//
// Overview of operation
// RQ1: Software quiesces timer before switching clock source
// RQ2: Processor clock exceeds four times crystal rate
// RQ3: Async writes land after two crystal edges
// RQ4: Each of five registers owns a temporary
// RQ5: Status shows pending transfers; no rewrite meanwhile
// RQ6: Busy set on write, cleared on transfer
// RQ7: Pending count or compare write blocks match
// RQ8: Wait busy clear before timer-woken sleep
// RQ9: Wait one crystal cycle before re-sleeping
// RQ10: Oscillator runs except power-down and standby
// RQ11: Registers lost after power-up; wait second
// RQ12: Wake-up starts on next timer cycle
// RQ13: Count read via register refreshed per edge
// RQ14: Wait busy clear before reading count
// RQ15: Flags take three cycles plus timer cycle
// RQ16: Async select moves source to crystal pin
// RQ17: Prescaler gives 1,8,32,64,128,256,1024, stop
// RQ18: Prescaler reset bit clears prescaler phase
// RQ19: Control A fields at 7:6, 5:4, 1:0
// RQ20: Nonzero output mode overrides port function
// RQ21: Non-PWM modes: off, toggle, clear, set
// RQ22: Fast PWM output modes per table
// RQ23: Fast PWM compare at TOP acts at bottom
// RQ24: Phase-correct output modes per count direction
// RQ25: Phase-correct compare at TOP acts at TOP
// RQ26: Waveform mode encoding with two TOP sources
// RQ27: Clock select encoding stop, 1, then dividers
`timescale 1ns/10ps
`default_nettype none
`include "ats_defines.vh"

module ats_timer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire xtal_in_pin,
    input wire sleep_power_down,
    input wire sleep_standby,
    output reg compare_out_a_pin,
    output reg compare_out_a_override,
    output reg xtal_port_disconnect,
    output reg osc_enable,
    output reg wake_req
);

    // ****************************************
    // Declarations
    // ****************************************
    reg xtal_meta_r;
    reg xtal_sync_r;
    reg xtal_prev_r;
    reg async_r;
    reg [7:0] count_r;
    reg count_down_r;
    reg [7:0] count_rd_r;
    reg [7:0] cmp_a_r;
    reg [7:0] cmp_b_r;
    reg [7:0] ctrl_a_r;
    reg [3:0] ctrl_b_r;
    reg [2:0] flags_r;
    reg [2:0] irq_en_r;
    reg [2:0] pend_r;
    reg [2:0] stg0_r;
    reg [2:0] stg1_r;
    reg [2:0] stg2_r;
    reg block_cmp_r;
    reg force_a_r;
    reg out_a_r;
    reg [7:0] count_nxt;
    reg count_down_nxt;
    reg out_a_nxt;
    reg [7:0] rd_nxt;
    reg map_hit;
    wire xtal_edge;
    wire src_tick;
    wire tick;
    wire wr_en;
    wire [7:0] wbyte;
    wire [4:0] wr_hit;
    wire [4:0] slot_busy;
    wire [4:0] slot_load;
    wire [7:0] v_cnt;
    wire [7:0] v_cmpa;
    wire [7:0] v_cmpb;
    wire [7:0] v_ctla;
    wire [7:0] v_ctlb;
    wire psr_wr;
    wire [1:0] com_a;
    wire [2:0] mode;
    wire [7:0] top;
    wire fast;
    wire pcor;
    wire at_top;
    wire hit_a;
    wire hit_b;
    wire ovf_evt;
    wire [2:0] evt;
    wire [2:0] flag_set;

    // ****************************************
    // Crystal pin synchroniser
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_meta_r <= 1'b0;
            xtal_sync_r <= 1'b0;
            xtal_prev_r <= 1'b0;
        end else begin
            xtal_meta_r <= xtal_in_pin;
            xtal_sync_r <= xtal_meta_r;
            xtal_prev_r <= xtal_sync_r;
        end
    end

    // Edge sampling only holds while pclk is over four times the crystal
    assign xtal_edge = xtal_sync_r & ~xtal_prev_r; // RQ2

    // ****************************************
    // APB access
    // ****************************************
    assign wr_en = psel & penable & pwrite & pready;
    assign wbyte = pwdata[7:0];
    assign wr_hit[0] = wr_en & (paddr == `ATS_OFF_COUNT);
    assign wr_hit[1] = wr_en & (paddr == `ATS_OFF_CMP_A);
    assign wr_hit[2] = wr_en & (paddr == `ATS_OFF_CMP_B);
    assign wr_hit[3] = wr_en & (paddr == `ATS_OFF_CTRL_A);
    assign wr_hit[4] = wr_en & (paddr == `ATS_OFF_CTRL_B);
    assign psr_wr = wr_en & (paddr == `ATS_OFF_GEN_CTRL) & wbyte[`ATS_GEN_PSR];

    always @* begin
        rd_nxt = `ATS_RST_BYTE;
        map_hit = 1'b1;
        case (paddr)
            `ATS_OFF_CTRL_A: rd_nxt = ctrl_a_r;
            `ATS_OFF_CTRL_B: rd_nxt = {4'h0, ctrl_b_r};
            `ATS_OFF_COUNT: rd_nxt = count_rd_r; // RQ13
            `ATS_OFF_CMP_A: rd_nxt = cmp_a_r;
            `ATS_OFF_CMP_B: rd_nxt = cmp_b_r;
            `ATS_OFF_ASYNC_STAT: rd_nxt = {2'b00, async_r, slot_busy[0], slot_busy[1],
                slot_busy[2], slot_busy[3], slot_busy[4]}; // RQ5
            `ATS_OFF_GEN_CTRL: rd_nxt = `ATS_RST_BYTE;
            `ATS_OFF_FLAGS: rd_nxt = {5'h00, flags_r};
            `ATS_OFF_IRQ_EN: rd_nxt = {5'h00, irq_en_r};
            default: map_hit = 1'b0;
        endcase
    end

    // One wait-free access phase; answer registered in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                prdata <= {24'h00_0000, rd_nxt};
                pslverr <= ~map_hit;
            end
        end
    end

    // ****************************************
    // Write holding slots
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_slot
            wire [7:0] sv;
            ats_upd_slot #(.W(8)) u_slot (
                .pclk(pclk),
                .presetn(presetn),
                .wr_async(wr_hit[gi] & async_r), // RQ3 RQ4
                .wr_sync(wr_hit[gi] & ~async_r),
                .wdata(wbyte),
                .xtal_edge(xtal_edge),
                .busy(slot_busy[gi]),
                .load(slot_load[gi]),
                .value(sv)
            );
        end
    endgenerate

    assign v_cnt = g_slot[0].sv;
    assign v_cmpa = g_slot[1].sv;
    assign v_cmpb = g_slot[2].sv;
    assign v_ctla = g_slot[3].sv;
    assign v_ctlb = g_slot[4].sv;

    // ****************************************
    // Configuration registers
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            async_r <= 1'b0;
            cmp_a_r <= `ATS_RST_BYTE;
            cmp_b_r <= `ATS_RST_BYTE;
            ctrl_a_r <= `ATS_RST_BYTE;
            ctrl_b_r <= 4'h0;
            irq_en_r <= 3'b000;
            force_a_r <= 1'b0;
        end else begin
            if (wr_en && paddr == `ATS_OFF_ASYNC_STAT) begin
                async_r <= wbyte[`ATS_STAT_AS]; // RQ16
            end
            if (wr_en && paddr == `ATS_OFF_IRQ_EN) begin
                irq_en_r <= wbyte[2:0];
            end
            if (slot_load[1]) begin
                cmp_a_r <= v_cmpa;
            end
            if (slot_load[2]) begin
                cmp_b_r <= v_cmpb;
            end
            if (slot_load[3]) begin
                ctrl_a_r <= {v_ctla[7:4], 2'b00, v_ctla[1:0]}; // RQ19
            end
            if (slot_load[4]) begin
                ctrl_b_r <= v_ctlb[3:0];
            end
            // Force strobe is never stored, it only waits for the next tick
            if (slot_load[4] && v_ctlb[`ATS_CTLB_FORCE_A]) begin
                force_a_r <= 1'b1;
            end else if (tick) begin
                force_a_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Clock source and prescaler
    // ****************************************
    assign src_tick = async_r ? xtal_edge : 1'b1; // RQ16

    ats_prescaler #(.PW(10)) u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick),
        .clear(psr_wr), // RQ18
        .sel(ctrl_b_r[2:0]),
        .tick(tick)
    );

    // ****************************************
    // Counter and waveform mode
    // ****************************************
    assign com_a = ctrl_a_r[7:6];
    assign mode = {ctrl_b_r[`ATS_CTLB_WGM_HI], ctrl_a_r[1:0]};
    assign top = mode[2] ? cmp_a_r : `ATS_MAX; // RQ26
    assign fast = (mode == `ATS_MODE_FAST_FF) | (mode == `ATS_MODE_FAST_OCR);
    assign pcor = (mode == `ATS_MODE_PC_FF) | (mode == `ATS_MODE_PC_OCR);
    assign at_top = (count_r == top);

    always @* begin
        count_nxt = count_r + 8'h01;
        count_down_nxt = 1'b0;
        if (pcor) begin
            if (!count_down_r && at_top) begin
                count_nxt = count_r - 8'h01;
                count_down_nxt = 1'b1;
            end else if (count_down_r && count_r != `ATS_BOTTOM) begin
                count_nxt = count_r - 8'h01;
                count_down_nxt = 1'b1;
            end
        end else if ((mode == `ATS_MODE_CTC || fast) && at_top) begin
            count_nxt = `ATS_BOTTOM; // RQ26
        end
    end

    // Pending count or compare writes mask the match of that channel
    assign hit_a = (count_r == cmp_a_r) & ~block_cmp_r & ~slot_busy[0] & ~slot_busy[1]; // RQ7
    assign hit_b = (count_r == cmp_b_r) & ~block_cmp_r & ~slot_busy[0] & ~slot_busy[2]; // RQ7
    assign ovf_evt = pcor ? (count_down_r && count_r == `ATS_BOTTOM) :
        (mode == `ATS_MODE_FAST_OCR) ? at_top : (count_r == `ATS_MAX);
    assign evt = {3{tick}} & {hit_b, hit_a, ovf_evt};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= `ATS_RST_BYTE;
            count_down_r <= 1'b0;
            count_rd_r <= `ATS_RST_BYTE;
            block_cmp_r <= 1'b0;
        end else begin
            if (slot_load[0]) begin
                count_r <= v_cnt;
                count_down_r <= 1'b0;
            end else if (tick) begin
                count_r <= count_nxt;
                count_down_r <= count_down_nxt;
            end
            // A fresh count value must not match on the very next tick
            if (slot_load[0]) begin
                block_cmp_r <= 1'b1;
            end else if (tick) begin
                block_cmp_r <= 1'b0;
            end
            // Holds the pre-sleep value until a crystal edge refreshes it
            if (!async_r || xtal_edge) begin
                count_rd_r <= count_r; // RQ13
            end
        end
    end

    // ****************************************
    // Channel A compare output
    // ****************************************
    always @* begin
        out_a_nxt = out_a_r;
        if (fast) begin
            if (com_a == 2'b01) begin
                if (mode[2] && hit_a) begin
                    out_a_nxt = ~out_a_r; // RQ22
                end
            end else if (com_a[1]) begin
                if (at_top) begin
                    out_a_nxt = ~com_a[0]; // RQ22 RQ23
                end else if (hit_a && cmp_a_r != top) begin
                    out_a_nxt = com_a[0]; // RQ23
                end
            end
        end else if (pcor) begin
            if (com_a == 2'b01) begin
                if (mode[2] && hit_a) begin
                    out_a_nxt = ~out_a_r; // RQ24
                end
            end else if (com_a[1]) begin
                if (cmp_a_r == top) begin
                    if (at_top && !count_down_r) begin
                        out_a_nxt = ~com_a[0]; // RQ25
                    end
                end else if (hit_a) begin
                    out_a_nxt = count_down_r ? ~com_a[0] : com_a[0]; // RQ24
                end
            end
        end else if (hit_a || force_a_r) begin
            case (com_a) // RQ21
                2'b01: out_a_nxt = ~out_a_r;
                2'b10: out_a_nxt = 1'b0;
                2'b11: out_a_nxt = 1'b1;
                default: out_a_nxt = out_a_r;
            endcase
        end
    end

    // Pin follows the timer tick directly, no processor-side resync
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_a_r <= 1'b0;
            compare_out_a_pin <= 1'b0;
            compare_out_a_override <= 1'b0;
        end else begin
            if (tick) begin
                out_a_r <= out_a_nxt; // RQ15
            end
            compare_out_a_pin <= tick ? out_a_nxt : out_a_r;
            compare_out_a_override <= (com_a != 2'b00); // RQ20
        end
    end

    // ****************************************
    // Interrupt flags and wake-up
    // ****************************************
    // Async: pend until next timer tick, then three pclk stages
    assign flag_set = async_r ? stg2_r : evt; // RQ15

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 3'b000;
            stg0_r <= 3'b000;
            stg1_r <= 3'b000;
            stg2_r <= 3'b000;
            flags_r <= 3'b000;
            wake_req <= 1'b0;
        end else begin
            pend_r <= tick ? evt : pend_r;
            stg0_r <= tick ? pend_r : 3'b000; // RQ15
            stg1_r <= stg0_r;
            stg2_r <= stg1_r;
            // Set wins over a write-one clear in the same cycle
            if (wr_en && paddr == `ATS_OFF_FLAGS) begin
                flags_r <= (flags_r & ~wbyte[2:0]) | flag_set;
            end else begin
                flags_r <= flags_r | flag_set;
            end
            if (async_r) begin
                wake_req <= tick & (|(pend_r & irq_en_r)); // RQ12
            end else begin
                wake_req <= |(evt & irq_en_r);
            end
        end
    end

    // ****************************************
    // Pin and oscillator control
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_port_disconnect <= 1'b0;
            osc_enable <= 1'b0;
        end else begin
            xtal_port_disconnect <= async_r; // RQ16
            osc_enable <= async_r & ~sleep_power_down & ~sleep_standby; // RQ10
        end
    end

endmodule // ats_timer

`default_nettype wire

//--- bench/ats_xtal_osc.sv
// Crystal oscillator model driving the timer's crystal input
`timescale 1ns/10ps
`default_nettype none
module ats_xtal_osc #(
    parameter int HALF_NS = 15259
) (
    input wire logic run,
    output logic xtal
);
// Held low while stopped, so a stale high never looks like a live edge
initial xtal = 1'b0;
always begin
    #(HALF_NS);
    xtal = run ? ~xtal : 1'b0;
end
endmodule // ats_xtal_osc
`default_nettype wire

//--- bench/ats_timer_sva.sv
// Checker on the timer's bus answers and pin outputs
`timescale 1ns/10ps
`default_nettype none
`include "ats_defines.vh"
module ats_timer_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire xtal_in_pin,
    input wire sleep_power_down,
    input wire sleep_standby,
    input wire compare_out_a_pin,
    input wire compare_out_a_override,
    input wire xtal_port_disconnect,
    input wire osc_enable,
    input wire wake_req
);
// ********
// Shadow state
// ********
logic async_r;
logic async_d_r;
logic osc_r;
logic xtal_q_r;
logic [3:0] since_r;
logic [1:0] mode_r;
wire wr = psel && penable && pready && pwrite;
wire mapped = paddr >= `ATS_OFF_CTRL_A && paddr <= `ATS_OFF_IRQ_EN && paddr[1:0] == 2'h0;
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        async_r <= 1'b0;
        async_d_r <= 1'b0;
        osc_r <= 1'b0;
        xtal_q_r <= 1'b0;
        since_r <= 4'hf;
        mode_r <= 2'h0;
    end else begin
        if (wr && paddr == `ATS_OFF_ASYNC_STAT) begin
            async_r <= pwdata[`ATS_STAT_AS];
        end
        if (wr && paddr == `ATS_OFF_CTRL_A) begin
            mode_r <= pwdata[7:6];
        end
        async_d_r <= async_r;
        osc_r <= async_r && !sleep_power_down && !sleep_standby;
        xtal_q_r <= xtal_in_pin;
        // Saturates so a stopped crystal never wraps into a fake recent edge
        if (xtal_in_pin && !xtal_q_r) begin
            since_r <= 4'h0;
        end else if (since_r != 4'hf) begin
            since_r <= since_r + 4'h1;
        end
    end
end
// ********
// Properties
// ********
sequence s_setup;
    psel && !penable;
endsequence
sequence s_ctrl_a_wr;
    wr && paddr == `ATS_OFF_CTRL_A && !async_r;
endsequence
a_ready_after_setup:
    assert property (s_setup |=> pready) else $error("no ready after setup");
a_ready_one_cycle:
    assert property (pready |=> !pready) else $error("ready held");
a_err_unmapped:
    assert property (pready |-> pslverr == !mapped) else $error("bad error answer");
a_ctrl_a_read:
    assert property (pready && !pwrite && paddr == `ATS_OFF_CTRL_A
        |-> prdata[31:8] == 24'h0 && prdata[3:2] == 2'h0) else $error("ctrl A readback");
a_override_mode:
    assert property (s_ctrl_a_wr |=> ##1 compare_out_a_override == (mode_r != 2'h0))
        else $error("override wrong");
a_port_disconnect:
    assert property (xtal_port_disconnect == async_d_r) else $error("port disconnect");
a_osc_sleep:
    assert property (osc_enable == osc_r) else $error("oscillator enable");
a_pin_on_tick:
    assert property (async_d_r && $changed(compare_out_a_pin) |-> since_r <= 4'h8)
        else $error("pin off timer clock");
a_wake_on_tick:
    assert property (wake_req && async_d_r |-> since_r <= 4'h8 ##1 !wake_req)
        else $error("wake pulse");
endmodule // ats_timer_sva
bind ats_timer ats_timer_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .xtal_in_pin, .sleep_power_down, .sleep_standby,
    .compare_out_a_pin, .compare_out_a_override, .xtal_port_disconnect, .osc_enable,
    .wake_req);
`default_nettype wire

//--- bench/async_timer_compare_output_bench.sv
// Self-checking bench for the asynchronous timer block
`timescale 1ns/10ps
`default_nettype none
`include "ats_defines.vh"
module async_timer_compare_output_bench;
// ********
// Harness
// ********
localparam int XHALF = 1000;
logic pclk, presetn, psel, penable, pwrite, sleep_power_down, sleep_standby, err, p0, wk;
logic [7:0] paddr;
logic [31:0] pwdata, rd;
wire [31:0] prdata;
wire pready, pslverr, xtal_in_pin, compare_out_a_pin, compare_out_a_override;
wire xtal_port_disconnect, osc_enable, wake_req;
int failures, n_compared, h, n;
time t0;
ats_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .xtal_in_pin, .sleep_power_down, .sleep_standby, .compare_out_a_pin,
    .compare_out_a_override, .xtal_port_disconnect, .osc_enable, .wake_req);
// Crystal sped up to keep the run short, still far below a quarter of pclk
ats_xtal_osc #(.HALF_NS(XHALF)) i_xtal (.run(osc_enable), .xtal(xtal_in_pin));
initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
end
always @(posedge pclk) begin
    if (wake_req === 1'b1) wk <= 1'b1;
end
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
        failures++;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
        @(posedge pclk);
        k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
endtask
task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
endtask
task automatic idle(input int c);
    repeat (c) @(negedge pclk);
endtask
task automatic busy_wait;
    n = 0;
    do begin
        rdr(`ATS_OFF_ASYNC_STAT);
        n++;
    end while (rd[4:0] !== 5'h0 && n < 400);
    if (rd[4:0] !== 5'h0) failures++;
endtask
task automatic highs(input int c, input int e, input int tol);
    h = 0;
    repeat (c) begin
        @(negedge pclk);
        h += compare_out_a_pin;
    end
    check(32'(h >= e - tol && h <= e + tol), 32'h1);
endtask
// ********
// Scenarios
// ********
task automatic t_regs;
    rdr(`ATS_OFF_CTRL_A);
    check(rd, 32'h0);
    wr(8'hd4, 32'hff);
    check(32'(err), 32'h1);
    wr(`ATS_OFF_CTRL_A, 32'hff);
    rdr(`ATS_OFF_CTRL_A);
    check(rd, 32'hf3);
    check(32'(compare_out_a_override), 32'h1);
    wr(`ATS_OFF_CTRL_A, 32'h0);
    idle(2);
    check(32'(compare_out_a_override), 32'h0);
endtask
task automatic t_nonpwm;
    logic [1:0] md[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic ex[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(`ATS_OFF_CMP_A, 32'h13);
    wr(`ATS_OFF_CTRL_B, 32'h1);
    for (int i = 0; i < 4; i++) begin
        wr(`ATS_OFF_COUNT, 32'h0);
        wr(`ATS_OFF_CTRL_A, {24'h0, md[i], 6'h0});
        idle(24);
        check(32'(compare_out_a_pin), 32'(ex[i]));
    end
    wr(`ATS_OFF_CTRL_B, 32'h81);
    idle(2);
    check(32'(compare_out_a_pin), 32'h1);
endtask
task automatic t_presc;
    int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    for (int i = 0; i < 8; i++) begin
        wr(`ATS_OFF_CTRL_B, i);
        wr(`ATS_OFF_GEN_CTRL, 32'h2);
        wr(`ATS_OFF_COUNT, 32'h11);
        p0 = compare_out_a_pin;
        idle(dv[i] / 2);
        check(32'(compare_out_a_pin), 32'(p0));
        idle(dv[i] * 3 + 8);
        check(32'(compare_out_a_pin), 32'(p0 ^ (dv[i] != 0)));
    end
endtask
task automatic t_pwm;
    wr(`ATS_OFF_CTRL_B, 32'h1);
    wr(`ATS_OFF_CMP_A, 32'h80);
    wr(`ATS_OFF_CTRL_A, 32'h83);
    idle(300);
    highs(512, 258, 6);
    wr(`ATS_OFF_CMP_A, 32'hff);
    idle(300);
    highs(512, 512, 0);
    wr(`ATS_OFF_CMP_A, 32'h40);
    wr(`ATS_OFF_CTRL_A, 32'h81);
    idle(600);
    highs(1020, 256, 8);
    wr(`ATS_OFF_CTRL_A, 32'hc1);
    idle(600);
    highs(1020, 764, 8);
endtask
task automatic t_async;
    wr(`ATS_OFF_CTRL_B, 32'h0);
    wr(`ATS_OFF_CTRL_A, 32'h40);
    wr(`ATS_OFF_ASYNC_STAT, 32'h20);
    idle(2);
    check(32'(xtal_port_disconnect), 32'h1);
    check(32'(osc_enable), 32'h1);
    t0 = $time;
    wr(`ATS_OFF_COUNT, 32'h55);
    wr(`ATS_OFF_CMP_A, 32'h4);
    rdr(`ATS_OFF_ASYNC_STAT);
    check(rd, 32'h38);
    busy_wait;
    check(rd, 32'h20);
    check(32'($time - t0 > 2 * XHALF), 32'h1);
    idle(100);
    rdr(`ATS_OFF_COUNT);
    check(rd, 32'h55);
    rdr(`ATS_OFF_CMP_A);
    check(rd, 32'h4);
    wr(`ATS_OFF_CTRL_B, 32'h1);
    busy_wait;
    wr(`ATS_OFF_FLAGS, 32'h7);
    wr(`ATS_OFF_IRQ_EN, 32'h2);
    wk = 1'b0;
    p0 = compare_out_a_pin;
    n = 0;
    while (compare_out_a_pin === p0 && n < 9000) begin
        idle(1);
        n++;
    end
    check(32'(compare_out_a_pin), 32'(!p0));
    idle(4 * XHALF / 50);
    check(32'(wk), 32'h1);
    rdr(`ATS_OFF_FLAGS);
    check(32'(rd[1]), 32'h1);
    wr(`ATS_OFF_CTRL_B, 32'h1);
    busy_wait;
    // Sleep states stop the crystal; check both, then recovery
    @(posedge pclk);
    sleep_standby <= 1'b1;
    idle(3);
    check(32'(osc_enable), 32'h0);
    @(posedge pclk);
    sleep_standby <= 1'b0;
    sleep_power_down <= 1'b1;
    idle(3);
    check(32'(osc_enable), 32'h0);
    @(posedge pclk);
    sleep_power_down <= 1'b0;
    idle(3);
    check(32'(osc_enable), 32'h1);
endtask
task automatic stop_test;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
        $display("DONE - PASS");
    end else begin
        $display("DONE - FAIL");
    end
    $finish;
endtask
initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_power_down, sleep_standby, wk} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    idle(1);
    t_regs;
    t_nonpwm;
    t_presc;
    t_pwm;
    t_async;
    stop_test;
end
// Whole run needs about 18k cycles; this allows over four times that
initial begin
    #4000000;
    failures++;
    stop_test;
end
endmodule // async_timer_compare_output_bench
`default_nettype wire
